// *** dual_clock_status_flag_fifo.sv ***
// Status-flag FIFO with standard and fall-through timing modes.
// Assumes all pins come from outside the clock domain and that the
// depth is a power of two, 1024 by default and 16 in the bench.
`timescale 1ns/1ps
module dual_clock_status_flag_fifo #(
   parameter int DATA_W = fifo_flag_pkg::DATA_W_DEF,
   parameter int DEPTH = fifo_flag_pkg::DEPTH_DEF
) (
   // Clock and master reset.
   input wire logic CLK,
   input wire logic RST_B,
   // Options caught at the end of master reset.
   input wire logic MODE_SELECT_SERIAL_IN,
   input wire logic FLAG_TIMING_SELECT,
   // Flag offsets.
   input wire logic [$clog2(DEPTH)-1:0] EMPTY_OFFSET,
   input wire logic [$clog2(DEPTH)-1:0] FULL_OFFSET,
   // Write port.
   input wire logic WRITE_ENABLE_N,
   input wire logic [DATA_W-1:0] WRITE_DATA_IN,
   output logic WRITE_READY,
   // Read port.
   input wire logic READ_ENABLE_N,
   output logic [DATA_W-1:0] READ_DATA_OUT,
   // Status flags.
   output logic EMPTY_INDICATOR_N,
   output logic FULL_INDICATOR_N,
   output logic OUTPUT_VALID_N,
   output logic INPUT_SPACE_N,
   output logic ALMOST_EMPTY_N,
   output logic ALMOST_FULL_N,
   output logic HALF_FULL_N
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam logic [PW-1:0] D_WORDS = PW'(DEPTH);
   localparam logic [PW-1:0] D_PLUS1 = PW'(DEPTH + 1);
   localparam logic [PW-1:0] HALF_D = PW'(DEPTH / 2);

   // Word count between two pointers; the spare bit resolves full.
   function automatic logic [PW-1:0] span(input logic [PW-1:0] head,
                                          input logic [PW-1:0] tail);
      span = head - tail;
   endfunction

   // Offset widened to count width plus an addend.
   function automatic logic [PW-1:0] widen(input logic [AW-1:0] off,
                                           input logic [PW-1:0] add);
      widen = PW'(off) + add;
   endfunction

   logic rst_meta_n;
   logic rst_n;
   logic wen_meta;
   logic wen_s;
   logic ren_meta;
   logic ren_s;
   logic [DATA_W-1:0] wdata_meta;
   logic [DATA_W-1:0] wdata_s;
   logic mode_meta;
   logic mode_s;
   logic pfm_meta;
   logic pfm_s;
   logic [AW-1:0] eoff_meta;
   logic [AW-1:0] eoff_s;
   logic [AW-1:0] foff_meta;
   logic [AW-1:0] foff_s;
   logic armed_reg;
   fifo_flag_pkg::timing_mode_t mode_reg;
   fifo_flag_pkg::flag_timing_t pfm_reg;
   logic [DATA_W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] wr_ptr_next;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW-1:0] rd_ptr_next;
   logic [PW-1:0] out_ptr_reg;
   logic [PW-1:0] out_ptr_next;
   logic [PW-1:0] wr_s1_reg;
   logic [PW-1:0] wr_s2_reg;
   logic [PW-1:0] out_s1_reg;
   logic [PW-1:0] out_s2_reg;
   logic [DATA_W-1:0] q_reg;
   logic [DATA_W-1:0] q_next;
   logic qv_reg;
   logic qv_next;
   logic full_stop_reg;
   logic full_stop_next;
   logic ef_reg, ef_next, ff_reg, ff_next;
   logic ov_reg, ov_next, ir_reg, ir_next;
   logic pae_reg, pae_next, paf_reg, paf_next, hf_reg, hf_next;
   logic buf_valid;
   logic buf_ready;
   logic [DATA_W-1:0] buf_data;
   logic buf_in_valid;
   logic drain;
   logic fall;
   logic [PW-1:0] mem_avail;
   logic [PW-1:0] rcount;
   logic [PW-1:0] wcount;
   logic [PW-1:0] wcount_next;
   logic [PW-1:0] true_count;
   logic [PW-1:0] pae_count;
   logic [PW-1:0] paf_count;
   logic consume;
   logic load;

   // Reset release through two flops; assertion stays asynchronous.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // Strobes rest idle under reset so no word moves before release.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         wen_meta <= fifo_flag_pkg::ENABLE_IDLE;
         wen_s <= fifo_flag_pkg::ENABLE_IDLE;
         ren_meta <= fifo_flag_pkg::ENABLE_IDLE;
         ren_s <= fifo_flag_pkg::ENABLE_IDLE;
      end else begin
         wen_meta <= WRITE_ENABLE_N;
         wen_s <= wen_meta;
         ren_meta <= READ_ENABLE_N;
         ren_s <= ren_meta;
      end
   end

   // Level pins are not reset, so straps are settled at the release.
   always_ff @(posedge CLK) begin
      wdata_meta <= WRITE_DATA_IN;
      wdata_s <= wdata_meta;
      mode_meta <= MODE_SELECT_SERIAL_IN;
      mode_s <= mode_meta;
      pfm_meta <= FLAG_TIMING_SELECT;
      pfm_s <= pfm_meta;
      eoff_meta <= EMPTY_OFFSET;
      eoff_s <= eoff_meta;
      foff_meta <= FULL_OFFSET;
      foff_s <= foff_meta;
   end

   // Straps are caught on the first edge after the release.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         armed_reg <= 1'b1;
         mode_reg <= fifo_flag_pkg::MODE_STANDARD;
         pfm_reg <= fifo_flag_pkg::FLAGS_SYNC;
      end else begin
         armed_reg <= 1'b0;
         if (armed_reg) begin
            mode_reg <= fifo_flag_pkg::timing_mode_t'(mode_s);
            pfm_reg <= fifo_flag_pkg::flag_timing_t'(pfm_s);
         end
      end
   end

   assign fall = (mode_reg == fifo_flag_pkg::MODE_FALL_THROUGH);

   // A full FIFO refuses new words at the buffer, not after it.
   assign buf_in_valid = !wen_s && !full_stop_reg && !armed_reg;

   pair_skid_buffer #(
      .WIDTH(DATA_W)
   ) u_in_buf (
      .clk(CLK),
      .rst_n(rst_n),
      .in_valid(buf_in_valid),
      .in_ready(buf_ready),
      .in_data(wdata_s),
      .out_valid(buf_valid),
      .out_ready(drain),
      .out_data(buf_data)
   );

   // Write side: the read pointer arrives two edges late, so the count
   // is pessimistic and never lets a write overrun a word.
   always_comb begin
      wcount = span(wr_ptr_reg, out_s2_reg);
      drain = fall ? (wcount < D_PLUS1) : (wcount < D_WORDS);
      // Only a word that really leaves the buffer moves the count, so an
      // idle port never shows one word more than is stored.
      wr_ptr_next = wr_ptr_reg + PW'(drain && buf_valid);
      wcount_next = wcount + PW'(drain && buf_valid);
      full_stop_next = fall ? (wcount_next == D_PLUS1)
                            : (wcount_next == D_WORDS);
      ff_next = fall ? fifo_flag_pkg::FULL_IND_RST
                     : (wcount_next != D_WORDS);
      ir_next = fall ? (wcount_next == D_PLUS1)
                     : fifo_flag_pkg::IN_SPACE_RST;
      if (fall) begin
         hf_next = !(wcount_next >= HALF_D + PW'(2));
      end else begin
         hf_next = !(wcount_next > HALF_D);
      end
   end

   // Memory write and write-side state; capture needs no reset.
   always_ff @(posedge CLK) begin
      if (drain && buf_valid) begin
         mem[wr_ptr_reg[AW-1:0]] <= buf_data;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         full_stop_reg <= 1'b0;
         ff_reg <= fifo_flag_pkg::FULL_IND_RST;
         ir_reg <= fifo_flag_pkg::IN_SPACE_RST;
         hf_reg <= fifo_flag_pkg::HALF_FULL_RST;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         full_stop_reg <= full_stop_next;
         ff_reg <= ff_next;
         ir_reg <= ir_next;
         hf_reg <= hf_next;
      end
   end

   // Pointer crossings, two stages each way.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         wr_s1_reg <= '0;
         wr_s2_reg <= '0;
         out_s1_reg <= '0;
         out_s2_reg <= '0;
      end else begin
         wr_s1_reg <= wr_ptr_reg;
         wr_s2_reg <= wr_s1_reg;
         out_s1_reg <= out_ptr_reg;
         out_s2_reg <= out_s1_reg;
      end
   end

   // Read side: standard mode moves a word only on request; fall-through
   // refills the output register by itself.
   always_comb begin
      mem_avail = span(wr_s2_reg, rd_ptr_reg);
      rd_ptr_next = rd_ptr_reg;
      out_ptr_next = out_ptr_reg;
      q_next = q_reg;
      qv_next = qv_reg;
      consume = 1'b0;
      load = 1'b0;
      if (!fall) begin
         if (!ren_s && (mem_avail != '0)) begin
            load = 1'b1;
            consume = 1'b1;
         end
      end else begin
         consume = !ren_s && qv_reg;
         load = (mem_avail != '0) && (!qv_reg || consume);
         qv_next = load || (qv_reg && !consume);
      end
      if (load) begin
         q_next = mem[rd_ptr_reg[AW-1:0]];
         rd_ptr_next = rd_ptr_reg + PW'(1);
      end
      if (consume) begin
         out_ptr_next = out_ptr_reg + PW'(1);
      end
      rcount = span(wr_s2_reg, out_ptr_next);
      ef_next = fall ? fifo_flag_pkg::EMPTY_IND_RST
                     : (rcount != '0);
      ov_next = fall ? !qv_next : fifo_flag_pkg::OUT_VALID_RST;
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rd_ptr_reg <= '0;
         out_ptr_reg <= '0;
         q_reg <= '0;
         qv_reg <= 1'b0;
         ef_reg <= fifo_flag_pkg::EMPTY_IND_RST;
         ov_reg <= fifo_flag_pkg::OUT_VALID_RST;
      end else begin
         rd_ptr_reg <= rd_ptr_next;
         out_ptr_reg <= out_ptr_next;
         q_reg <= q_next;
         qv_reg <= qv_next;
         ef_reg <= ef_next;
         ov_reg <= ov_next;
      end
   end

   // Almost flags: synchronous timing counts on each flag's own side,
   // asynchronous timing reacts to both pointers at once.
   always_comb begin
      true_count = span(wr_ptr_reg, out_ptr_reg);
      if (pfm_reg == fifo_flag_pkg::FLAGS_SYNC) begin
         pae_count = span(wr_s2_reg, out_ptr_next);
         paf_count = wcount_next;
      end else begin
         pae_count = true_count;
         paf_count = true_count;
      end
      // Offsets are AW bits wide, so they cannot exceed depth minus one.
      if (fall) begin
         pae_next = pae_count >= widen(eoff_s, PW'(2));
         paf_next = !(paf_count >= D_PLUS1 - PW'(foff_s));
      end else begin
         pae_next = pae_count >= widen(eoff_s, PW'(1));
         paf_next = !(paf_count >= D_WORDS - PW'(foff_s));
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pae_reg <= fifo_flag_pkg::ALMOST_EMPTY_RST;
         paf_reg <= fifo_flag_pkg::ALMOST_FULL_RST;
      end else begin
         pae_reg <= pae_next;
         paf_reg <= paf_next;
      end
   end

   // Every output is a flop of this block or of the input buffer.
   assign WRITE_READY = buf_ready;
   assign READ_DATA_OUT = q_reg;
   assign EMPTY_INDICATOR_N = ef_reg;
   assign FULL_INDICATOR_N = ff_reg;
   assign OUTPUT_VALID_N = ov_reg;
   assign INPUT_SPACE_N = ir_reg;
   assign ALMOST_EMPTY_N = pae_reg;
   assign ALMOST_FULL_N = paf_reg;
   assign HALF_FULL_N = hf_reg;
endmodule

// *** dual_clock_status_flag_fifo_tb.sv ***
// Self-checking bench for the status-flag FIFO with a 16-word memory.
// Assumes the peer model and the bound monitor are compiled beside it.
`timescale 1ns/1ps
module dual_clock_status_flag_fifo_tb;
   localparam int DW = fifo_flag_pkg::DATA_W_DEF;
   typedef struct {
      logic rst;
      logic md;
      logic [3:0] n;
      logic [3:0] m;
      logic [4:0] add;
      logic [6:0] exp;
   } row_t;
   // Reset, mode, offsets, words to add, then flags expected after them.
   // Flags read {empty, full, valid, space, almost-empty, almost-full, half}.
   row_t rows [20] = '{
      '{1, 0, 0, 0, 1, 7'h77},
      '{0, 0, 0, 0, 14, 7'h76},
      '{0, 0, 0, 0, 1, 7'h54},
      '{1, 0, 3, 2, 3, 7'h73},
      '{0, 0, 3, 2, 1, 7'h77},
      '{0, 0, 3, 2, 4, 7'h77},
      '{0, 0, 3, 2, 1, 7'h76},
      '{0, 0, 3, 2, 4, 7'h76},
      '{0, 0, 3, 2, 1, 7'h74},
      '{0, 0, 3, 2, 2, 7'h54},
      '{0, 0, 3, 2, 2, 7'h54},
      '{1, 1, 3, 2, 1, 7'h23},
      '{0, 1, 3, 2, 3, 7'h23},
      '{0, 1, 3, 2, 1, 7'h27},
      '{0, 1, 3, 2, 4, 7'h27},
      '{0, 1, 3, 2, 1, 7'h26},
      '{0, 1, 3, 2, 4, 7'h26},
      '{0, 1, 3, 2, 1, 7'h24},
      '{0, 1, 3, 2, 2, 7'h2C},
      '{0, 1, 3, 2, 2, 7'h2C}
   };
   logic clk, rst_b, mode, fts, wgo, rgo, wen_n, ren_n, wready;
   logic ef, ff, ov, ir, almost_empty_n, almost_full_n, hf;
   logic [3:0] n_off, m_off;
   logic [DW-1:0] wdata, rdata;
   int bad_count = 0;
   int samples_checked = 0;
   int i;
   // Free-running 125 MHz clock.
   always #4 clk = ~clk;
   dual_clock_status_flag_fifo #(.DEPTH(16)) uut (
      .CLK(clk), .RST_B(rst_b), .MODE_SELECT_SERIAL_IN(mode),
      .FLAG_TIMING_SELECT(fts), .EMPTY_OFFSET(n_off), .FULL_OFFSET(m_off),
      .WRITE_ENABLE_N(wen_n), .WRITE_DATA_IN(wdata), .WRITE_READY(wready),
      .READ_ENABLE_N(ren_n), .READ_DATA_OUT(rdata),
      .EMPTY_INDICATOR_N(ef), .FULL_INDICATOR_N(ff), .OUTPUT_VALID_N(ov),
      .INPUT_SPACE_N(ir), .ALMOST_EMPTY_N(almost_empty_n), .ALMOST_FULL_N(almost_full_n),
      .HALF_FULL_N(hf)
   );
   fifo_peer peer (
      .clk(clk), .rst_n(rst_b), .write_go(wgo), .read_go(rgo),
      .write_enable_n(wen_n), .write_data(wdata), .read_enable_n(ren_n)
   );
   // The k-th word the peer writes after a reset.
   function automatic logic [DW-1:0] word(input int k);
      word = {4'h5, 32'(k)};
   endfunction
   // Flags expected after a read leaves rem words; zero means no check.
   function automatic logic [6:0] drain_exp(input logic md, input int rem);
      case ({md, 5'(rem)})
         6'h0F: drain_exp = 7'h74;
         6'h0D: drain_exp = 7'h76;
         6'h08: drain_exp = 7'h77;
         6'h03: drain_exp = 7'h73;
         6'h30: drain_exp = 7'h24;
         6'h2E: drain_exp = 7'h26;
         6'h29: drain_exp = 7'h27;
         6'h24: drain_exp = 7'h23;
         6'h00, 6'h20: drain_exp = 7'h33;
         default: drain_exp = 7'h00;
      endcase
   endfunction
   task automatic cmp_flags(input logic [7:0] exp);
      logic [7:0] got;
      got = {wready, ef, ff, ov, ir, almost_empty_n, almost_full_n, hf};
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t flags %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [DW-1:0] exp);
      samples_checked++;
      if (rdata !== exp) begin
         bad_count++;
         $display("mismatch at %0t data %h expected %h", $time, rdata, exp);
      end
   endtask
   // Straps are set for the whole reset, as the mode is caught there.
   task automatic do_reset(input logic md, input logic [3:0] n, m);
      @(negedge clk);
      rst_b = 1'h0;
      mode = md;
      fts = !md;
      n_off = n;
      m_off = m;
      repeat (20) @(negedge clk);
      cmp_flags(8'h33);
      cmp_word(36'h0);
      rst_b = 1'h1;
      repeat (12) @(negedge clk);
   endtask
   // Back-to-back writes, then time for both sides' flags to settle.
   task automatic push(input int k);
      wgo <= 1'h1;
      repeat (k) @(negedge clk);
      wgo <= 1'h0;
      repeat (14) @(negedge clk);
   endtask
   task automatic pull();
      rgo <= 1'h1;
      @(negedge clk);
      rgo <= 1'h0;
      repeat (12) @(negedge clk);
   endtask
   // Read everything back in order, then once more against empty.
   task automatic drain(input logic md, input int total);
      logic [6:0] e;
      for (int j = 0; j < total; j++) begin
         if (md) cmp_word(word(j));
         pull();
         if (!md) cmp_word(word(j));
         e = drain_exp(md, total - 1 - j);
         if (e != 7'h00) cmp_flags({1'h1, e});
      end
      pull();
      cmp_flags(8'hB3);
      cmp_word(word(total - 1));
   endtask
   task automatic summarize();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Main sequence: table of fill levels, then both drains.
   initial begin
      clk = 1'h0;
      rst_b = 1'h0;
      mode = 1'h0;
      fts = 1'h1;
      n_off = 4'h0;
      m_off = 4'h0;
      wgo = 1'h0;
      rgo = 1'h0;
      for (i = 0; i < 20; i++) begin
         if (rows[i].rst) do_reset(rows[i].md, rows[i].n, rows[i].m);
         push(rows[i].add);
         cmp_flags({1'h1, rows[i].exp});
      end
      drain(1'h1, 17);
      do_reset(1'h0, 4'h3, 4'h2);
      push(16);
      drain(1'h0, 16);
      summarize();
   end
   // A hang well past the expected run length ends the test as failed.
   initial begin
      #50000;
      bad_count++;
      summarize();
   end
endmodule

// *** fifo_flag_pkg.sv ***
// Shared constants for the status-flag FIFO and its input buffer.
// Assumes nothing of its surroundings; every user names items with pkg::.
package fifo_flag_pkg;
   // Default data width and memory depth in words.
   localparam int DATA_W_DEF = 36;
   localparam int DEPTH_DEF = 1024;
   // Entries in the skid buffer on the write path.
   localparam int BUF_ENTRIES = 2;
   // Timing mode caught at the end of master reset.
   typedef enum logic {
      MODE_STANDARD = 1'b0,
      MODE_FALL_THROUGH = 1'b1
   } timing_mode_t;
   // Almost-flag update style caught at the end of master reset.
   typedef enum logic {
      FLAGS_ASYNC = 1'b0,
      FLAGS_SYNC = 1'b1
   } flag_timing_t;
   // Reset levels of the flag outputs (all active low).
   localparam logic EMPTY_IND_RST = 1'b0;
   localparam logic FULL_IND_RST = 1'b1;
   localparam logic OUT_VALID_RST = 1'b1;
   localparam logic IN_SPACE_RST = 1'b0;
   localparam logic ALMOST_EMPTY_RST = 1'b0;
   localparam logic ALMOST_FULL_RST = 1'b1;
   localparam logic HALF_FULL_RST = 1'b1;
   // Level that inactive enables and synchronised strobes rest at.
   localparam logic ENABLE_IDLE = 1'b1;
endpackage

// *** fifo_peer.sv ***
// Writer and reader logic on the far side of the FIFO pins.
// Assumes the bench changes write_go and read_go at a falling edge.
`timescale 1ns/1ps
module fifo_peer (
   // Clock and bench reset.
   input wire logic clk,
   input wire logic rst_n,
   // Requests from the bench.
   input wire logic write_go,
   input wire logic read_go,
   // Pins toward the FIFO.
   output logic write_enable_n,
   output logic [fifo_flag_pkg::DATA_W_DEF-1:0] write_data,
   output logic read_enable_n
);
   logic [31:0] word_count;
   // Pins move at the falling edge, so the FIFO samples settled levels.
   // Idle data is inverted so a stale word never passes for a new one.
   always @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_count <= 32'h0;
         write_enable_n <= 1'h1;
         write_data <= 36'h0;
         read_enable_n <= 1'h1;
      end else begin
         write_enable_n <= !write_go;
         read_enable_n <= !read_go;
         if (write_go) begin
            write_data <= {4'h5, word_count};
            word_count <= word_count + 32'h1;
         end else begin
            write_data <= ~write_data;
         end
      end
   end
endmodule

// *** flag_fifo_monitor.sv ***
// Concurrent checks on the pins of the status-flag FIFO.
// Assumes the mode strap only moves while master reset is low.
`timescale 1ns/1ps
module flag_fifo_monitor #(
   parameter int DATA_W = fifo_flag_pkg::DATA_W_DEF
) (
   // Clock, reset and mode strap.
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic MODE_SELECT_SERIAL_IN,
   // Data pins.
   input wire logic WRITE_ENABLE_N,
   input wire logic WRITE_READY,
   input wire logic READ_ENABLE_N,
   input wire logic [DATA_W-1:0] READ_DATA_OUT,
   // Status flags.
   input wire logic EMPTY_INDICATOR_N,
   input wire logic FULL_INDICATOR_N,
   input wire logic OUTPUT_VALID_N,
   input wire logic INPUT_SPACE_N,
   input wire logic ALMOST_EMPTY_N,
   input wire logic ALMOST_FULL_N,
   input wire logic HALF_FULL_N
);
   // One clock domain, so clock and reset are given once.
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // Flags of the unused mode rest at their reset levels.
   std_idle_a:
   assert property (!MODE_SELECT_SERIAL_IN |->
      OUTPUT_VALID_N && !INPUT_SPACE_N)
      else $error("standard mode moved fall-through flags");
   fall_through_mode_idle_a:
   assert property (MODE_SELECT_SERIAL_IN |->
      !EMPTY_INDICATOR_N && FULL_INDICATOR_N)
      else $error("fall-through mode moved standard flags");
   // Full implies the lower write-side thresholds have all been passed.
   std_full_a:
   assert property (!MODE_SELECT_SERIAL_IN && !FULL_INDICATOR_N |->
      EMPTY_INDICATOR_N && !HALF_FULL_N && !ALMOST_FULL_N)
      else $error("full shown without lower flags");
   fall_through_mode_full_a:
   assert property (MODE_SELECT_SERIAL_IN && INPUT_SPACE_N |->
      !OUTPUT_VALID_N && !HALF_FULL_N && !ALMOST_FULL_N)
      else $error("no input space shown without lower flags");
   std_empty_a:
   assert property (!MODE_SELECT_SERIAL_IN && !EMPTY_INDICATOR_N |->
      FULL_INDICATOR_N && HALF_FULL_N)
      else $error("empty shown with full or half-full");
   // Without reads a full FIFO stays full, whatever is written.
   full_hold_a:
   assert property ((!MODE_SELECT_SERIAL_IN && !FULL_INDICATOR_N &&
      READ_ENABLE_N)[*8] |=> !FULL_INDICATOR_N)
      else $error("full released with no read");
   space_hold_a:
   assert property ((MODE_SELECT_SERIAL_IN && INPUT_SPACE_N &&
      READ_ENABLE_N)[*8] |=> INPUT_SPACE_N)
      else $error("input space returned with no read");
   // Reads against an empty FIFO leave the output word alone.
   empty_hold_a:
   assert property ((!MODE_SELECT_SERIAL_IN && !EMPTY_INDICATOR_N &&
      WRITE_ENABLE_N)[*8] |=> !EMPTY_INDICATOR_N && $stable(READ_DATA_OUT))
      else $error("empty FIFO changed its output");
   valid_hold_a:
   assert property ((MODE_SELECT_SERIAL_IN && OUTPUT_VALID_N &&
      WRITE_ENABLE_N)[*8] |=> OUTPUT_VALID_N && $stable(READ_DATA_OUT))
      else $error("drained FIFO changed its output");
   // A first word into an empty FIFO shows within a bounded pipeline.
   first_word_a:
   assert property ((MODE_SELECT_SERIAL_IN && OUTPUT_VALID_N &&
      WRITE_ENABLE_N)[*8] ##1 (!WRITE_ENABLE_N && WRITE_READY) |->
      OUTPUT_VALID_N[*5] ##[1:6] !OUTPUT_VALID_N)
      else $error("first word did not fall through in time");
   first_ef_a:
   assert property ((!MODE_SELECT_SERIAL_IN && !EMPTY_INDICATOR_N &&
      WRITE_ENABLE_N)[*8] ##1 (!WRITE_ENABLE_N && WRITE_READY) |->
      !EMPTY_INDICATOR_N[*5] ##[1:6] EMPTY_INDICATOR_N)
      else $error("empty indicator did not rise in time");
endmodule
bind dual_clock_status_flag_fifo flag_fifo_monitor #(.DATA_W(DATA_W)) mon (
   .CLK(CLK), .RST_B(RST_B), .MODE_SELECT_SERIAL_IN(MODE_SELECT_SERIAL_IN),
   .WRITE_ENABLE_N(WRITE_ENABLE_N), .WRITE_READY(WRITE_READY),
   .READ_ENABLE_N(READ_ENABLE_N), .READ_DATA_OUT(READ_DATA_OUT),
   .EMPTY_INDICATOR_N(EMPTY_INDICATOR_N), .FULL_INDICATOR_N(FULL_INDICATOR_N),
   .OUTPUT_VALID_N(OUTPUT_VALID_N), .INPUT_SPACE_N(INPUT_SPACE_N),
   .ALMOST_EMPTY_N(ALMOST_EMPTY_N), .ALMOST_FULL_N(ALMOST_FULL_N),
   .HALF_FULL_N(HALF_FULL_N)
);

// *** pair_skid_buffer.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an active-low reset already synchronised.
`timescale 1ns/1ps
module pair_skid_buffer #(
   parameter int WIDTH = fifo_flag_pkg::DATA_W_DEF
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [1:0] count_reg;
   logic [1:0] count_next;
   logic [WIDTH-1:0] head_reg;
   logic [WIDTH-1:0] head_next;
   logic [WIDTH-1:0] tail_reg;
   logic [WIDTH-1:0] tail_next;
   logic ready_reg;
   logic valid_reg;
   logic push;
   logic pop;

   assign in_ready = ready_reg;
   assign out_valid = valid_reg;
   assign out_data = head_reg;

   // The head slot always holds the oldest word, so the drain side reads a
   // flop and never a multiplexer.
   always_comb begin
      push = in_valid && ready_reg;
      pop = valid_reg && out_ready;
      count_next = count_reg;
      head_next = head_reg;
      tail_next = tail_reg;
      if (push && !pop) begin
         if (count_reg == 2'h0) begin
            head_next = in_data;
         end else begin
            tail_next = in_data;
         end
         count_next = count_reg + 2'h1;
      end else if (pop && !push) begin
         head_next = tail_reg;
         count_next = count_reg - 2'h1;
      end else if (pop && push) begin
         if (count_reg == 2'h1) begin
            head_next = in_data;
         end else begin
            head_next = tail_reg;
            tail_next = in_data;
         end
      end
   end

   // Ready and valid are registered from the next count.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 2'h0;
         head_reg <= '0;
         tail_reg <= '0;
         ready_reg <= 1'b0;
         valid_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         head_reg <= head_next;
         tail_reg <= tail_next;
         ready_reg <= (count_next != 2'(fifo_flag_pkg::BUF_ENTRIES));
         valid_reg <= (count_next != 2'h0);
      end
   end
endmodule
